// [fcs_consts.svh]
// Register offsets, field positions, count limits, security code and command codes of the flash sequencer
`ifndef FCS_CONSTS_SVH
`define FCS_CONSTS_SVH

`define FCS_OFF_DIV 8'h00
`define FCS_OFF_PROT 8'h04
`define FCS_OFF_STAT 8'h08
`define FCS_OFF_CMD 8'h0C
`define FCS_OFF_ADDR 8'h10
`define FCS_OFF_DATA 8'h14

`define FCS_ST_CBEF 7
`define FCS_ST_CCF 6
`define FCS_ST_PVIOL 5
`define FCS_ST_ACCERR 4
`define FCS_ST_BLANK 2
`define FCS_PROT_DIS 0
`define FCS_DIV_LD 7
`define FCS_DIV_PRE 6

`define FCS_CMD_BLANK 8'h05
`define FCS_CMD_BYTE 8'h20
`define FCS_CMD_BURST 8'h25
`define FCS_CMD_PAGE 8'h40
`define FCS_CMD_MASS 8'h41

`define FCS_PAGE_LOW 9'h1FF
`define FCS_PRESCALE_LAST 3'h7
`define FCS_SEC_UNSECURED 2'h2

`endif

// [fcs_pkg.sv]
// Types of the flash sequencer
package fcs_pkg;
  typedef enum logic [1:0] {
    FCS_SEQ_IDLE = 2'b00,
    FCS_SEQ_DATA = 2'b01,
    FCS_SEQ_CMD = 2'b11
  } fcs_seq_t;
  typedef enum logic {
    FCS_ARR_IDLE = 1'b0,
    FCS_ARR_RUN = 1'b1
  } fcs_arr_t;
endpackage

// [fcs_clkdiv.sv]
// Write-once flash clock divider and timing tick
`timescale 1ns/1ps
`include "fcs_consts.svh"
module fcs_clkdiv (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [6:0] wdata,
  output logic divld,
  output logic prdiv8,
  output logic [5:0] div,
  output logic tick
);
  logic [2:0] pre;
  logic [5:0] cnt;

  // Divider setting, loaded once after reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      divld <= 1'b0;
      prdiv8 <= 1'b0;
      div <= 6'h00;
    end else if (wr_en && !divld) begin
      divld <= 1'b1;
      prdiv8 <= wdata[`FCS_DIV_PRE];
      div <= wdata[5:0];
    end
  end

  // Bus clock divided by (div+1), or 8*(div+1)
  always_ff @(posedge clk) begin
    if (!rst_n || !divld) begin
      pre <= 3'h0;
      cnt <= 6'h00;
      tick <= 1'b0;
    end else if (prdiv8 && pre != `FCS_PRESCALE_LAST) begin
      pre <= pre + 3'h1;
      tick <= 1'b0;
    end else begin
      pre <= 3'h0;
      tick <= (cnt == div);
      cnt <= (cnt == div) ? 6'h00 : cnt + 6'h01;
    end
  end
endmodule // fcs_clkdiv

// [fcs_prot.sv]
// Protection boundary check and protection write filter
`timescale 1ns/1ps
`include "fcs_consts.svh"
module fcs_prot (
  input wire logic [7:0] prot,
  input wire logic [7:0] wdata,
  input wire logic [7:0] cmd,
  input wire logic [15:0] addr,
  output logic hit,
  output logic [7:0] next_prot
);
  logic [15:0] unprot_end;

  always_comb begin
    unprot_end = {prot[7:1], `FCS_PAGE_LOW};
    hit = 1'b0;
    if (!prot[`FCS_PROT_DIS] && cmd != `FCS_CMD_BLANK) begin
      hit = (cmd == `FCS_CMD_MASS) || (addr > unprot_end);
    end
    next_prot = prot;
    if (!prot[`FCS_PROT_DIS] && !wdata[`FCS_PROT_DIS] && wdata[7:1] <= prot[7:1]) begin
      next_prot = wdata;
    end
  end
endmodule // fcs_prot

// [fcs_top.sv]
// Flash command, status and protection sequencer with APB register access
// Function
// - With protection on, boundary field bits 7:1 end the unprotected region.
// - Protection bit 0 low enforces boundary; high protects nothing.
// - Writing 1 to buffer-empty bit 7 launches; flag clears, sets again on transfer to the array.
// - Only burst program commands can be buffered behind a running burst; flag shows buffer empty or full.
// - Complete bit 6 set when buffer empty and idle; writes ignored.
// - Program or erase of protected location is ignored, sets bit 5, write-1 clears.
// - Access error bit 4 on sequence error, program or erase with divider uninitialised, or stop while busy.
// - Writing 1 clears access error; writing 0 leaves it.
// - Blank check finding all 0xFF sets bit 2; next valid launch clears it.
// - Codes 0x05 blank check, 0x20 byte program, 0x25 burst program.
// - Codes 0x40 page erase of 512 bytes, 0x41 mass erase.
// - Any other command code raises an access error.
// - Protection register loaded from nonvolatile copy during reset; always readable.
// - Protection writes may only lower the boundary; none while disabled.
// - Successful blank check sets security state code to 1:0.
`timescale 1ns/1ps
`include "fcs_consts.svh"
module fcs_top (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [7:0] NONVOLATILE_PROTECTION_COPY,
  input wire logic [1:0] NONVOLATILE_SECURITY,
  input wire logic STOP_ENTRY,
  input wire logic ARR_DONE,
  input wire logic ARR_BLANK_OK,
  output logic ARR_START,
  output logic [7:0] ARR_CMD,
  output logic [15:0] ARR_ADDR,
  output logic [7:0] ARR_DATA,
  output logic ARR_FCLK_EN,
  output logic [1:0] SECURITY_STATE_CODE
);
  logic [7:0] flash_protection;
  logic [7:0] flash_command;
  logic [15:0] tgt_addr;
  logic [7:0] tgt_data;
  logic cbef, ccf, pviol, accerr, blank;
  fcs_pkg::fcs_seq_t seq, next_seq;
  fcs_pkg::fcs_arr_t arr_state, next_arr;
  logic buf_valid, next_buf_valid;
  logic [7:0] buf_cmd;
  logic [15:0] buf_addr;
  logic [7:0] buf_data;
  logic divld, prdiv8;
  logic [5:0] div;
  logic prot_hit;
  logic [7:0] next_prot;
  logic access, wr, hit_addr;
  logic wr_div, wr_prot, wr_stat, wr_cmd, wr_addr, wr_data;
  logic [7:0] rd_mux;
  logic launch_try, launch_at_cmd, legal, prog_erase, run_conflict;
  logic launch_ok, transfer, acc_set, pv_set, blank_set, stop_err, seq_err;
  logic next_cbef;

  // APB decode
  always_comb begin
    access = PSEL && PENABLE && PREADY;
    wr = access && PWRITE;
    wr_div = wr && PADDR == `FCS_OFF_DIV;
    wr_prot = wr && PADDR == `FCS_OFF_PROT;
    wr_stat = wr && PADDR == `FCS_OFF_STAT;
    wr_cmd = wr && PADDR == `FCS_OFF_CMD;
    wr_addr = wr && PADDR == `FCS_OFF_ADDR;
    wr_data = wr && PADDR == `FCS_OFF_DATA;
    hit_addr = 1'b1;
    rd_mux = 8'h00;
    case (PADDR)
      `FCS_OFF_DIV: rd_mux = {divld, prdiv8, div};
      `FCS_OFF_PROT: rd_mux = flash_protection;
      `FCS_OFF_STAT: rd_mux = {cbef, ccf, pviol, accerr, 1'b0, blank, 2'b00};
      `FCS_OFF_CMD: rd_mux = flash_command;
      `FCS_OFF_ADDR: rd_mux = 8'h00;
      `FCS_OFF_DATA: rd_mux = tgt_data;
      default: hit_addr = 1'b0;
    endcase
  end

  // One wait state on every transfer
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= PSEL && PENABLE && !PREADY;
      if (PSEL && PENABLE && !PREADY) begin
        PRDATA <= (PADDR == `FCS_OFF_ADDR) ? {16'h0000, tgt_addr} : {24'h00_0000, rd_mux};
        PSLVERR <= !hit_addr;
      end
    end
  end

  fcs_clkdiv u_clkdiv (
    .clk(CLK),
    .rst_n(RST_N),
    .wr_en(wr_div),
    .wdata(PWDATA[6:0]),
    .divld(divld),
    .prdiv8(prdiv8),
    .div(div),
    .tick(ARR_FCLK_EN)
  );

  fcs_prot u_prot (
    .prot(flash_protection),
    .wdata(PWDATA[7:0]),
    .cmd(flash_command),
    .addr(tgt_addr),
    .hit(prot_hit),
    .next_prot(next_prot)
  );

  // Command checks and sequencing
  always_comb begin
    legal = flash_command == `FCS_CMD_BLANK || flash_command == `FCS_CMD_BYTE
      || flash_command == `FCS_CMD_BURST || flash_command == `FCS_CMD_PAGE
      || flash_command == `FCS_CMD_MASS;
    prog_erase = flash_command != `FCS_CMD_BLANK;
    run_conflict = arr_state == fcs_pkg::FCS_ARR_RUN
      && (flash_command != `FCS_CMD_BURST || ARR_CMD != `FCS_CMD_BURST);
    launch_try = wr_stat && PWDATA[`FCS_ST_CBEF] && cbef;
    launch_at_cmd = launch_try && seq == fcs_pkg::FCS_SEQ_CMD;
    seq_err = (launch_try && seq != fcs_pkg::FCS_SEQ_CMD)
      || (wr_data && !cbef)
      || (wr_cmd && seq != fcs_pkg::FCS_SEQ_DATA);
    stop_err = STOP_ENTRY && (arr_state == fcs_pkg::FCS_ARR_RUN || buf_valid);
    acc_set = seq_err || stop_err
      || (launch_at_cmd && (!legal || (prog_erase && !divld) || run_conflict));
    pv_set = launch_at_cmd && !acc_set && prot_hit;
    launch_ok = launch_at_cmd && !acc_set && !prot_hit;
    transfer = buf_valid && arr_state == fcs_pkg::FCS_ARR_IDLE && !stop_err;
    blank_set = ARR_DONE && arr_state == fcs_pkg::FCS_ARR_RUN
      && ARR_CMD == `FCS_CMD_BLANK && ARR_BLANK_OK;
    next_seq = seq;
    case (seq)
      fcs_pkg::FCS_SEQ_IDLE: if (wr_data && cbef) next_seq = fcs_pkg::FCS_SEQ_DATA;
      fcs_pkg::FCS_SEQ_DATA: if (wr_cmd) next_seq = fcs_pkg::FCS_SEQ_CMD;
      fcs_pkg::FCS_SEQ_CMD: if (launch_try) next_seq = fcs_pkg::FCS_SEQ_IDLE;
      default: next_seq = fcs_pkg::FCS_SEQ_IDLE;
    endcase
    if (acc_set || pv_set) begin
      next_seq = fcs_pkg::FCS_SEQ_IDLE;
    end
    next_buf_valid = buf_valid;
    next_cbef = cbef;
    if (transfer || stop_err) begin
      next_buf_valid = 1'b0;
      next_cbef = 1'b1;
    end
    if (launch_ok) begin
      next_buf_valid = 1'b1;
      next_cbef = 1'b0;
    end
    next_arr = arr_state;
    case (arr_state)
      fcs_pkg::FCS_ARR_IDLE: if (transfer) next_arr = fcs_pkg::FCS_ARR_RUN;
      fcs_pkg::FCS_ARR_RUN: if (ARR_DONE) next_arr = fcs_pkg::FCS_ARR_IDLE;
      default: next_arr = fcs_pkg::FCS_ARR_IDLE;
    endcase
  end

  // Target address, data and command holding registers
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      tgt_addr <= 16'h0000;
      tgt_data <= 8'h00;
      flash_command <= 8'h00;
    end else begin
      if (wr_addr) tgt_addr <= PWDATA[15:0];
      if (wr_data) tgt_data <= PWDATA[7:0];
      if (wr_cmd) flash_command <= PWDATA[7:0];
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) seq <= fcs_pkg::FCS_SEQ_IDLE;
    else seq <= next_seq;
  end

  // One-entry command buffer
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      buf_valid <= 1'b0;
      buf_cmd <= 8'h00;
      buf_addr <= 16'h0000;
      buf_data <= 8'h00;
    end else begin
      buf_valid <= next_buf_valid;
      if (launch_ok) begin
        buf_cmd <= flash_command;
        buf_addr <= tgt_addr;
        buf_data <= tgt_data;
      end
    end
  end

  // Array launch
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      arr_state <= fcs_pkg::FCS_ARR_IDLE;
      ARR_START <= 1'b0;
      ARR_CMD <= 8'h00;
      ARR_ADDR <= 16'h0000;
      ARR_DATA <= 8'h00;
    end else begin
      arr_state <= next_arr;
      ARR_START <= transfer;
      if (transfer) begin
        ARR_CMD <= buf_cmd;
        ARR_ADDR <= buf_addr;
        ARR_DATA <= buf_data;
      end
    end
  end

  // Status flags; a set in the clearing cycle wins
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      cbef <= 1'b1;
      ccf <= 1'b1;
      pviol <= 1'b0;
      accerr <= 1'b0;
      blank <= 1'b0;
    end else begin
      cbef <= next_cbef;
      ccf <= next_cbef && next_arr == fcs_pkg::FCS_ARR_IDLE;
      pviol <= pv_set || (pviol && !(wr_stat && PWDATA[`FCS_ST_PVIOL]));
      accerr <= acc_set || (accerr && !(wr_stat && PWDATA[`FCS_ST_ACCERR]));
      blank <= blank_set || (blank && !launch_ok);
    end
  end

  // Protection and security state
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      flash_protection <= NONVOLATILE_PROTECTION_COPY;
      SECURITY_STATE_CODE <= NONVOLATILE_SECURITY;
    end else begin
      if (wr_prot) flash_protection <= next_prot;
      if (blank_set) SECURITY_STATE_CODE <= `FCS_SEC_UNSECURED;
    end
  end

  a_launch_clears_cbef: assert property (@(posedge CLK) disable iff (!RST_N)
    launch_ok |=> !cbef && buf_valid) else $error("launch did not clear buffer empty");
  a_ccf_when_idle: assert property (@(posedge CLK) disable iff (!RST_N)
    ccf |-> !buf_valid && arr_state == fcs_pkg::FCS_ARR_IDLE && !ARR_START)
    else $error("complete flag set while a command is pending");
  a_pviol_ignores: assert property (@(posedge CLK) disable iff (!RST_N)
    pv_set |=> pviol && cbef && !buf_valid ##1 !ARR_START)
    else $error("protected command not ignored");
  a_accerr_write_one: assert property (@(posedge CLK) disable iff (!RST_N)
    wr_stat && PWDATA[`FCS_ST_ACCERR] && !acc_set |=> !accerr)
    else $error("access error not cleared by write one");
  a_accerr_write_zero: assert property (@(posedge CLK) disable iff (!RST_N)
    wr_stat && !PWDATA[`FCS_ST_ACCERR] && accerr |=> accerr)
    else $error("access error lost on write zero");
  a_illegal_cmd: assert property (@(posedge CLK) disable iff (!RST_N)
    launch_at_cmd && !legal |=> accerr && !buf_valid && seq == fcs_pkg::FCS_SEQ_IDLE)
    else $error("illegal command not rejected");
  a_prot_only_up: assert property (@(posedge CLK) disable iff (!RST_N)
    wr_prot |=> flash_protection[7:1] <= $past(flash_protection[7:1])
      || $past(flash_protection[`FCS_PROT_DIS]))
    else $error("protection boundary raised");
  a_prot_dis_locked: assert property (@(posedge CLK) disable iff (!RST_N)
    flash_protection[`FCS_PROT_DIS] |=> $stable(flash_protection))
    else $error("disabled protection changed");
  a_blank_unsecures: assert property (@(posedge CLK) disable iff (!RST_N)
    blank_set |=> blank && SECURITY_STATE_CODE == `FCS_SEC_UNSECURED)
    else $error("blank check result not recorded");
  a_buf_transfer: assert property (@(posedge CLK) disable iff (!RST_N)
    transfer |=> ARR_START && cbef && arr_state == fcs_pkg::FCS_ARR_RUN ##1 !ARR_START)
    else $error("buffered command not transferred");
  a_apb_wait: assert property (@(posedge CLK) disable iff (!RST_N)
    PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY)
    else $error("ready not after one wait state");
  a_ccf_on_done: assert property (@(posedge CLK) disable iff (!RST_N)
    ARR_DONE && arr_state == fcs_pkg::FCS_ARR_RUN && cbef && !launch_ok |=> ccf)
    else $error("complete flag not set after last command");
  a_launch_clears_ccf: assert property (@(posedge CLK) disable iff (!RST_N)
    launch_ok |=> !ccf)
    else $error("launch did not clear complete flag");
  a_pviol_write_one: assert property (@(posedge CLK) disable iff (!RST_N)
    wr_stat && PWDATA[`FCS_ST_PVIOL] && !pv_set |=> !pviol)
    else $error("protection violation not cleared by write one");
  a_blank_cleared: assert property (@(posedge CLK) disable iff (!RST_N)
    launch_ok && !blank_set |=> !blank)
    else $error("blank flag kept after launch");
  a_stop_error: assert property (@(posedge CLK) disable iff (!RST_N)
    stop_err |=> accerr && cbef && !buf_valid)
    else $error("stop entry while busy not flagged");
  a_div_needed: assert property (@(posedge CLK) disable iff (!RST_N)
    launch_at_cmd && prog_erase && !divld |=> accerr && !buf_valid)
    else $error("program or erase ran without divider");
  a_prot_reset_load: assert property (@(posedge CLK)
    !RST_N |=> flash_protection == $past(NONVOLATILE_PROTECTION_COPY) && !ARR_START)
    else $error("protection not loaded during reset");
endmodule // fcs_top

// [fcs_array_model.sv]
// Behavioural flash array answering launched operations
`timescale 1ns/1ps
module fcs_array_model (
  input wire logic clk,
  input wire logic start,
  input wire logic [7:0] cmd,
  input wire logic [7:0] latency,
  input wire logic erased,
  output logic done,
  output logic blank_ok
);
  int cnt = 0;
  logic busy = 1'b0;
  initial begin
    done = 1'b0;
    blank_ok = 1'b0;
  end
  // Blank result only valid with done; toggles otherwise
  always @(posedge clk) begin
    done <= 1'b0;
    blank_ok <= ~blank_ok;
    if (start === 1'b1) begin
      busy <= 1'b1;
      cnt <= latency;
    end else if (busy && cnt == 0) begin
      busy <= 1'b0;
      done <= 1'b1;
      blank_ok <= erased && cmd == 8'h05;
    end else if (busy) begin
      cnt <= cnt - 1;
    end
  end
endmodule // fcs_array_model

// [tb_top.sv]
// Self-checking bench for the flash command sequencer
`timescale 1ns/1ps
module tb_top;
  logic CLK = 1'b0, RST_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic STOP_ENTRY = 1'b0, erased = 1'b0, m_blank = 1'b0, m_div = 1'b0, slverr;
  logic [7:0] PADDR = 8'h00, nv_prot, lat = 8'h03, m_prot, m_data, st_cmd, st_data;
  logic [31:0] PWDATA = 32'h0000_0000, PRDATA, rd;
  logic PREADY, PSLVERR, ARR_DONE, ARR_BLANK_OK, ARR_START, ARR_FCLK_EN;
  logic [7:0] ARR_CMD, ARR_DATA;
  logic [15:0] ARR_ADDR, st_addr;
  logic [1:0] SECURITY_STATE_CODE, nv_sec = 2'b01;
  integer seed = 28;
  int bad_count = 0, n_compared = 0, n_start = 0, cyc = 0, s0 = 0;
  int n_fclk = 0, fclk_gap = 0, fclk_last = 0;
  logic [7:0] codes [5] = '{8'h05, 8'h20, 8'h25, 8'h40, 8'h41};

  fcs_top i_fcs_top (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .NONVOLATILE_PROTECTION_COPY(nv_prot), .NONVOLATILE_SECURITY(nv_sec),
    .STOP_ENTRY(STOP_ENTRY), .ARR_DONE(ARR_DONE), .ARR_BLANK_OK(ARR_BLANK_OK),
    .ARR_START(ARR_START), .ARR_CMD(ARR_CMD), .ARR_ADDR(ARR_ADDR), .ARR_DATA(ARR_DATA),
    .ARR_FCLK_EN(ARR_FCLK_EN), .SECURITY_STATE_CODE(SECURITY_STATE_CODE));
  fcs_array_model i_fcs_array_model (.clk(CLK), .start(ARR_START), .cmd(ARR_CMD),
    .latency(lat), .erased(erased), .done(ARR_DONE), .blank_ok(ARR_BLANK_OK));

  always #5 CLK = ~CLK;

  // Start monitor and hang limit
  always @(posedge CLK) begin
    cyc++;
    if (ARR_START === 1'b1) begin
      n_start++;
      st_cmd = ARR_CMD;
      st_addr = ARR_ADDR;
      st_data = ARR_DATA;
    end
    if (ARR_FCLK_EN === 1'b1) begin
      n_fclk++;
      fclk_gap = cyc - fclk_last;
      fclk_last = cyc;
    end
    if (cyc == 20000) begin
      bad_count++;
      report_and_stop;
    end
  end

  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", w, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK);
      k++;
    end while (PREADY !== 1'b1 && k < 50);
    rd = PRDATA;
    slverr = PSLVERR;
    chk("pready", 1, PREADY);
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  // Reference outcome: 0x10 access error, 0x20 violation, 0 accepted
  function automatic logic [7:0] outcome(input logic [7:0] c, input logic [15:0] a);
    if (!(c inside {8'h05, 8'h20, 8'h25, 8'h40, 8'h41}) || (!m_div && c != 8'h05))
      return 8'h10;
    if (!m_prot[0] && (c == 8'h41 || (c != 8'h05 && a > {m_prot[7:1], 9'h1FF})))
      return 8'h20;
    return 8'h00;
  endfunction

  task automatic wait_ccf;
    int k;
    k = 0;
    do begin
      apb(0, 8'h08, 0);
      k++;
    end while (rd[6] !== 1'b1 && k < 60);
    chk("complete", 1, rd[6]);
  endtask

  task automatic launch(input logic [7:0] c, input logic [15:0] a);
    m_data = 8'($random(seed));
    apb(1, 8'h10, {16'h0000, a});
    apb(1, 8'h14, {24'h00_0000, m_data});
    apb(1, 8'h0C, {24'h00_0000, c});
    apb(1, 8'h08, 32'h0000_0080);
  endtask

  task automatic run_cmd(input logic [7:0] c, input logic [15:0] a);
    logic [7:0] e;
    e = outcome(c, a);
    s0 = n_start;
    launch(c, a);
    apb(0, 8'h08, 0);
    if (e !== 8'h00) begin
      chk("error flags", e, rd & 32'h30);
      apb(1, 8'h08, 32'h0000_0000);
      apb(0, 8'h08, 0);
      chk("flags kept", e, rd & 32'h30);
      apb(1, 8'h08, {24'h00_0000, e});
      apb(0, 8'h08, 0);
      chk("ignored", s0, n_start);
    end else begin
      wait_ccf;
      m_blank = (c == 8'h05) && erased;
      chk("started", s0 + 1, n_start);
      chk("array op", {c, a, m_data}, {st_cmd, st_addr, st_data});
    end
    chk("status", 32'h0000_00C0 | 32'(m_blank) << 2, rd);
  endtask

  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    nv_prot = {7'h20 + 7'($random(seed) & 32'h3F), 1'b0};
    m_prot = nv_prot;
    repeat (6) @(posedge CLK);
    RST_N <= 1'b1;
    apb(0, 8'h08, 0);
    chk("reset status", 32'h0000_00C0, rd);
    apb(0, 8'h04, 0);
    chk("prot load", m_prot, rd);
    apb(0, 8'h18, 0);
    chk("unmapped", 1, slverr);
    run_cmd(8'h20, 16'h0000);
    chk("fclk idle", 0, n_fclk);
    apb(1, 8'h00, 32'h0000_0001);
    m_div = 1'b1;
    for (int i = 0; i < 4; i++) run_cmd(8'h80 | 8'(i * 3 + 1), 16'h0000);
    chk("fclk gap", 2, fclk_gap);
    apb(1, 8'h0C, 32'h0000_0020);
    apb(1, 8'h08, 32'h0000_0080);
    apb(0, 8'h08, 0);
    chk("sequence", 32'h10, rd & 32'h30);
    apb(1, 8'h08, 32'h0000_0010);
    erased = 1'b1;
    foreach (codes[i]) run_cmd(codes[i], 16'($random(seed)) & 16'h3FFF);
    chk("security", 2'b10, SECURITY_STATE_CODE);
    run_cmd(8'h20, {m_prot[7:1], 9'h1FF});
    run_cmd(8'h40, {m_prot[7:1], 9'h1FF} + 16'h0001);
    apb(1, 8'h04, {24'h00_0000, m_prot + 8'h03});
    apb(0, 8'h04, 0);
    chk("prot raise", m_prot, rd);
    m_prot = m_prot - 8'h02;
    apb(1, 8'h04, {24'h00_0000, m_prot});
    apb(0, 8'h04, 0);
    chk("prot lower", m_prot, rd);
    run_cmd(8'h20, {m_prot[7:1] + 7'h01, 9'h1FF});
    lat = 8'd60;
    s0 = n_start;
    launch(8'h25, 16'h0010);
    launch(8'h25, 16'h0011);
    apb(0, 8'h08, 0);
    chk("buffer full", 32'h00, rd & 32'hC0);
    wait_ccf;
    chk("burst pair", {16'(s0 + 2), 16'h0011}, {16'(n_start), st_addr});
    launch(8'h20, 16'h0020);
    @(posedge CLK);
    STOP_ENTRY <= 1'b1;
    @(posedge CLK);
    STOP_ENTRY <= 1'b0;
    apb(0, 8'h08, 0);
    chk("stop", 32'h10, rd & 32'h10);
    apb(1, 8'h08, 32'h0000_0010);
    wait_ccf;
    for (int i = 0; i < 12; i++) begin
      lat = 8'($random(seed)) & 8'h07;
      erased = 1'($random(seed));
      run_cmd(codes[$unsigned($random(seed)) % 5], 16'($random(seed)));
    end
    RST_N <= 1'b0;
    nv_prot <= 8'h01;
    nv_sec <= 2'b11;
    repeat (2) @(posedge CLK);
    RST_N <= 1'b1;
    m_prot = 8'h01;
    m_div = 1'b0;
    m_blank = 1'b0;
    apb(0, 8'h08, 0);
    chk("restart status", 32'h0000_00C0, rd);
    chk("restart security", 2'b11, SECURITY_STATE_CODE);
    apb(0, 8'h04, 0);
    chk("restart prot", m_prot, rd);
    apb(1, 8'h00, 32'h0000_0041);
    apb(1, 8'h00, 32'h0000_0002);
    apb(0, 8'h00, 0);
    chk("divider", 32'h0000_00C1, rd);
    m_div = 1'b1;
    run_cmd(8'h41, 16'h0000);
    run_cmd(8'h20, 16'hFFFF);
    apb(1, 8'h04, 32'h0000_0000);
    apb(0, 8'h04, 0);
    chk("prot locked", m_prot, rd);
    chk("fclk prescaled", 16, fclk_gap);
    report_and_stop;
  end
endmodule // tb_top
